// ==== hw/itm_pkg.sv ====
// ****************************************************************
// io range trap monitor: shared constants and types
// ****************************************************************
package itm_pkg;

  // bus and datapath widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int IO_ADDR_W = 16;
  localparam int MASK_W = 4;
  localparam int REG_W = 8;
  localparam int NUM_SLOTS = 2;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_R4_LO = 8'hA0;
  localparam logic [7:0] IDX_R4_HI = 8'hA1;
  localparam logic [7:0] IDX_R5_LO = 8'hA2;
  localparam logic [7:0] IDX_R5_HI = 8'hA3;
  localparam logic [7:0] IDX_STATUS = 8'hA8;
  localparam logic [7:0] IDX_IRQ_EN = 8'hA9;
  localparam logic [7:0] IDX_TRAP = 8'hAA;

  // byte addresses on the register bus
  localparam logic [ADDR_W-1:0] ADDR_R4_LO = ADDR_W'({IDX_R4_LO, 2'h0});
  localparam logic [ADDR_W-1:0] ADDR_R4_HI = ADDR_W'({IDX_R4_HI, 2'h0});
  localparam logic [ADDR_W-1:0] ADDR_R5_LO = ADDR_W'({IDX_R5_LO, 2'h0});
  localparam logic [ADDR_W-1:0] ADDR_R5_HI = ADDR_W'({IDX_R5_HI, 2'h0});
  localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'({IDX_STATUS, 2'h0});
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = ADDR_W'({IDX_IRQ_EN, 2'h0});
  localparam logic [ADDR_W-1:0] ADDR_TRAP = ADDR_W'({IDX_TRAP, 2'h0});

  // field positions of the low register
  localparam int LO_MASK_LSB = 0;
  localparam int LO_BASE_LSB = 4;

  // field positions of the trap capture register
  localparam int TRAP_ADDR_LSB = 0;
  localparam int TRAP_WRITE_BIT = 16;
  localparam int TRAP_SLOT_LSB = 17;

  // reset values
  localparam logic [REG_W-1:0] RST_LO = 8'h00;
  localparam logic [REG_W-1:0] RST_HI = 8'h00;
  localparam logic [NUM_SLOTS-1:0] RST_STATUS = 2'h0;
  localparam logic [NUM_SLOTS-1:0] RST_IRQ_EN = 2'h3;
  localparam logic [IO_ADDR_W-1:0] RST_TRAP_ADDR = 16'h0000;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one host i/o cycle, valid for a single clock
  typedef struct packed {
    logic valid;
    logic write;
    logic [IO_ADDR_W-1:0] addr;
  } itm_io_access_t;

  // programmed range of one slot
  typedef struct packed {
    logic [REG_W-1:0] base_high_byte;
    logic [MASK_W-1:0] base_low_nibble;
    logic [MASK_W-1:0] low_bit_mask;
  } itm_slot_cfg_t;

endpackage

// ==== hw/itm_slot_match.sv ====
`timescale 1ns/1ps
// ****************************************************************
// one range comparator slot
// ****************************************************************
module itm_slot_match (
  // programmed range
  input wire itm_pkg::itm_slot_cfg_t cfg,
  // observed host cycle
  input wire itm_pkg::itm_io_access_t io,
  // result
  output logic hit
);

  logic [itm_pkg::IO_ADDR_W-1:0] base;
  logic upper_eq;
  logic low_ok;

  // base built from high byte and low nibble, low four bits zero
  assign base = {cfg.base_high_byte, cfg.base_low_nibble, {itm_pkg::MASK_W{1'b0}}};

  // bits above the mask field must equal the base exactly
  assign upper_eq = (io.addr[itm_pkg::IO_ADDR_W-1:itm_pkg::MASK_W]
    == base[itm_pkg::IO_ADDR_W-1:itm_pkg::MASK_W]);

  // masked bits are don't care, unmasked low bits must be zero
  assign low_ok = ((io.addr[itm_pkg::MASK_W-1:0] & ~cfg.low_bit_mask) == '0);

  assign hit = io.valid & upper_eq & low_ok;

endmodule

// ==== hw/itm_top.sv ====
`timescale 1ns/1ps
// ****************************************************************
// io range trap monitor, two slots behind an axi4-lite slave
// ****************************************************************

// Behaviour
// - Each slot compares a 16-bit host i/o address, with a 4-bit mask covering only bits 3:0.
// - A set mask bit removes that low address bit from the comparison.
// - A clear mask bit requires that low address bit of the access to be zero.
// - Bits 7:4 of the low register give base address bits 7:4 in the same order.
// - The high register byte gives base address bits 15:8, bit 7 to bit 15.
// - A host i/o access matching a slot raises the system management interrupt.
module itm_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [itm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [itm_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [itm_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [itm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [itm_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // host i/o cycle being observed
  input wire itm_pkg::itm_io_access_t io_access,
  // interrupt to the processor
  output logic system_management_interrupt
);

  // ****************************************************************
  // types and storage
  // ****************************************************************

  typedef enum logic [0:0] {
    WR_IDLE,
    WR_RESP
  } itm_wr_state_t;

  typedef enum logic [0:0] {
    RD_IDLE,
    RD_DATA
  } itm_rd_state_t;

  itm_wr_state_t wr_state_reg;
  itm_wr_state_t wr_state_next;
  itm_rd_state_t rd_state_reg;
  itm_rd_state_t rd_state_next;

  // write channel holding latches
  logic aw_held_reg;
  logic w_held_reg;
  logic [itm_pkg::ADDR_W-1:0] aw_addr_reg;
  logic [itm_pkg::DATA_W-1:0] w_data_reg;
  logic [itm_pkg::STRB_W-1:0] w_strb_reg;
  logic [1:0] bresp_reg;

  // read channel answer
  logic [itm_pkg::DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;

  // slot registers, index 0 is slot four, index 1 is slot five
  logic [itm_pkg::REG_W-1:0] low_reg [itm_pkg::NUM_SLOTS];
  logic [itm_pkg::REG_W-1:0] high_reg [itm_pkg::NUM_SLOTS];

  // interrupt status, enable and capture of the last trapped cycle
  logic [itm_pkg::NUM_SLOTS-1:0] status_reg;
  logic [itm_pkg::NUM_SLOTS-1:0] status_next;
  logic [itm_pkg::NUM_SLOTS-1:0] irq_en_reg;
  logic [itm_pkg::IO_ADDR_W-1:0] trap_addr_reg;
  logic trap_write_reg;
  logic [itm_pkg::NUM_SLOTS-1:0] trap_slot_reg;
  logic irq_reg;

  // ****************************************************************
  // handshakes and decode
  // ****************************************************************

  logic aw_take;
  logic w_take;
  logic do_write;
  logic ar_take;
  logic wr_lane0;
  logic status_read;
  logic [itm_pkg::NUM_SLOTS-1:0] slot_hit;
  logic any_hit;
  itm_pkg::itm_slot_cfg_t slot_cfg [itm_pkg::NUM_SLOTS];

  // a channel stays open until its beat is parked
  assign s_axi_awready = ~aw_held_reg;
  assign s_axi_wready = ~w_held_reg;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;

  // the write is done once both halves are parked and no answer is pending
  assign do_write = aw_held_reg & w_held_reg & (wr_state_reg == WR_IDLE);
  assign wr_lane0 = w_strb_reg[0]; // writable registers live in byte lane 0 only

  assign s_axi_bvalid = (wr_state_reg == WR_RESP);
  assign s_axi_bresp = bresp_reg;

  // one read at a time; a new address waits until the data is taken
  assign s_axi_arready = (rd_state_reg == RD_IDLE);
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign s_axi_rvalid = (rd_state_reg == RD_DATA);
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  assign status_read = ar_take & (s_axi_araddr == itm_pkg::ADDR_STATUS);

  // true for every address that has a register behind it
  function automatic logic is_mapped(input logic [itm_pkg::ADDR_W-1:0] a);
    case (a)
      itm_pkg::ADDR_R4_LO,
      itm_pkg::ADDR_R4_HI,
      itm_pkg::ADDR_R5_LO,
      itm_pkg::ADDR_R5_HI,
      itm_pkg::ADDR_STATUS,
      itm_pkg::ADDR_IRQ_EN,
      itm_pkg::ADDR_TRAP: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // range comparators
  // ****************************************************************

  // each slot sees its own registers and the same host cycle
  generate
    for (genvar i = 0; i < itm_pkg::NUM_SLOTS; i++) begin : g_slot
      assign slot_cfg[i].base_high_byte = high_reg[i];
      assign slot_cfg[i].base_low_nibble = low_reg[i][itm_pkg::LO_BASE_LSB +: itm_pkg::MASK_W];
      assign slot_cfg[i].low_bit_mask = low_reg[i][itm_pkg::LO_MASK_LSB +: itm_pkg::MASK_W];
      itm_slot_match u_match (
        .cfg(slot_cfg[i]),
        .io(io_access),
        .hit(slot_hit[i])
      );
    end
  endgenerate

  assign any_hit = |slot_hit;

  // ****************************************************************
  // write channel
  // ****************************************************************

  // park the address beat until the write is carried out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (aw_take) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  // park the data beat; either beat may come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (w_take) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // response state
  always_comb begin
    wr_state_next = wr_state_reg;
    case (wr_state_reg)
      WR_IDLE: begin
        if (do_write) begin
          wr_state_next = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          wr_state_next = WR_IDLE;
        end
      end
      default: wr_state_next = WR_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= WR_IDLE;
      bresp_reg <= itm_pkg::RESP_OKAY;
    end else begin
      wr_state_reg <= wr_state_next;
      if (do_write) begin
        bresp_reg <= is_mapped(aw_addr_reg) ? itm_pkg::RESP_OKAY : itm_pkg::RESP_SLVERR;
      end
    end
  end

  // slot registers; a write without lane 0 leaves them alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < itm_pkg::NUM_SLOTS; i++) begin
        low_reg[i] <= itm_pkg::RST_LO;
        high_reg[i] <= itm_pkg::RST_HI;
      end
    end else if (do_write && wr_lane0) begin
      case (aw_addr_reg)
        itm_pkg::ADDR_R4_LO: low_reg[0] <= w_data_reg[itm_pkg::REG_W-1:0];
        itm_pkg::ADDR_R4_HI: high_reg[0] <= w_data_reg[itm_pkg::REG_W-1:0];
        itm_pkg::ADDR_R5_LO: low_reg[1] <= w_data_reg[itm_pkg::REG_W-1:0];
        itm_pkg::ADDR_R5_HI: high_reg[1] <= w_data_reg[itm_pkg::REG_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // interrupt enable register, same layout as status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_reg <= itm_pkg::RST_IRQ_EN;
    end else if (do_write && wr_lane0 && (aw_addr_reg == itm_pkg::ADDR_IRQ_EN)) begin
      irq_en_reg <= w_data_reg[itm_pkg::NUM_SLOTS-1:0];
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************

  always_comb begin
    rd_state_next = rd_state_reg;
    case (rd_state_reg)
      RD_IDLE: begin
        if (ar_take) begin
          rd_state_next = RD_DATA;
        end
      end
      RD_DATA: begin
        if (s_axi_rready) begin
          rd_state_next = RD_IDLE;
        end
      end
      default: rd_state_next = RD_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= RD_IDLE;
    end else begin
      rd_state_reg <= rd_state_next;
    end
  end

  // data is latched at the address beat, so a status read returns
  // the bits that the same edge clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_reg <= '0;
      rresp_reg <= itm_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rdata_reg <= '0;
      rresp_reg <= itm_pkg::RESP_OKAY;
      case (s_axi_araddr)
        itm_pkg::ADDR_R4_LO: rdata_reg[itm_pkg::REG_W-1:0] <= low_reg[0];
        itm_pkg::ADDR_R4_HI: rdata_reg[itm_pkg::REG_W-1:0] <= high_reg[0];
        itm_pkg::ADDR_R5_LO: rdata_reg[itm_pkg::REG_W-1:0] <= low_reg[1];
        itm_pkg::ADDR_R5_HI: rdata_reg[itm_pkg::REG_W-1:0] <= high_reg[1];
        itm_pkg::ADDR_STATUS: rdata_reg[itm_pkg::NUM_SLOTS-1:0] <= status_reg;
        itm_pkg::ADDR_IRQ_EN: rdata_reg[itm_pkg::NUM_SLOTS-1:0] <= irq_en_reg;
        itm_pkg::ADDR_TRAP: begin
          rdata_reg[itm_pkg::TRAP_ADDR_LSB +: itm_pkg::IO_ADDR_W] <= trap_addr_reg;
          rdata_reg[itm_pkg::TRAP_WRITE_BIT] <= trap_write_reg;
          rdata_reg[itm_pkg::TRAP_SLOT_LSB +: itm_pkg::NUM_SLOTS] <= trap_slot_reg;
        end
        default: rresp_reg <= itm_pkg::RESP_SLVERR; // unmapped reads as zero
      endcase
    end
  end

  // ****************************************************************
  // trap events and interrupt
  // ****************************************************************

  // a hit in the cycle of the clearing read survives: set wins
  always_comb begin
    status_next = status_reg;
    if (status_read) begin
      status_next = '0;
    end
    status_next = status_next | slot_hit;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= itm_pkg::RST_STATUS;
    end else begin
      status_reg <= status_next;
    end
  end

  // capture of the most recent trapped cycle for the handler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trap_addr_reg <= itm_pkg::RST_TRAP_ADDR;
      trap_write_reg <= 1'b0;
      trap_slot_reg <= '0;
    end else if (any_hit) begin
      trap_addr_reg <= io_access.addr;
      trap_write_reg <= io_access.write;
      trap_slot_reg <= slot_hit;
    end
  end

  // registered level; changes on the same edge as status, no glitches on the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_next & irq_en_reg);
    end
  end

  assign system_management_interrupt = irq_reg;

  // ****************************************************************
  // unused inputs
  // ****************************************************************

  // protection bits carry no meaning for this block
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot, w_data_reg[itm_pkg::DATA_W-1:itm_pkg::REG_W]};

endmodule

// ==== tb/io_range_trap_monitor_bench.sv ====
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench for the io range trap monitor
// ****************************************************************
module io_range_trap_monitor_bench;
  // table row: slot, low byte, high byte, host address, expected status
  typedef struct packed {
    logic s;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [15:0] a;
    logic [1:0] st;
  } itm_row_t;
  itm_row_t rows [11] = '{
    '{1'h0, 8'hA3, 8'h80, 16'h80A0, 2'h1},
    '{1'h0, 8'hA3, 8'h80, 16'h80A3, 2'h1},
    '{1'h0, 8'hA3, 8'h80, 16'h80A4, 2'h0},
    '{1'h0, 8'hA3, 8'h80, 16'h80B0, 2'h0},
    '{1'h0, 8'hA3, 8'h80, 16'h8020, 2'h0},
    '{1'h0, 8'hA3, 8'h80, 16'h81A0, 2'h0},
    '{1'h0, 8'hA3, 8'h80, 16'h00A0, 2'h0},
    '{1'h0, 8'h5F, 8'h01, 16'h015F, 2'h1},
    '{1'h1, 8'hC8, 8'hFE, 16'hFEC8, 2'h2},
    '{1'h1, 8'hC8, 8'hFE, 16'hFEC0, 2'h2},
    '{1'h1, 8'hC8, 8'hFE, 16'hFEC1, 2'h0}};
  logic [11:0] ra [7] = '{itm_pkg::ADDR_R4_LO, itm_pkg::ADDR_R4_HI, itm_pkg::ADDR_R5_LO,
    itm_pkg::ADDR_R5_HI, itm_pkg::ADDR_STATUS, itm_pkg::ADDR_IRQ_EN, itm_pkg::ADDR_TRAP};
  logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h3, 32'h0};
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] aw_a = 12'h0, ar_a = 12'h0;
  logic [31:0] w_d = 32'h0, d, r_d;
  logic aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0;
  logic [3:0] w_s = 4'hF;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq;
  logic [1:0] b_resp, r_resp, r;
  itm_pkg::itm_io_access_t io;
  int err_total = 0;
  int n_tests = 0;

  // 10 mhz clock
  always #50 aclk = ~aclk;

  itm_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(w_s),
    .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
    .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arprot(3'h0), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
    .s_axi_rready(r_r), .io_access(io), .system_management_interrupt(irq));
  itm_host_model i_host (.aclk(aclk), .io_access(io));

  // ****************************************************************
  // compares, bus tasks, verdict
  // ****************************************************************
  task chk32(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t word %h expected %h", $time, g, e);
    end
  endtask
  task chk1(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t flag %b expected %b", $time, g, e);
    end
  endtask
  // handshakes judged at the falling edge, where nothing moves, acted on at the next rise
  task axw(input logic [11:0] a, input logic [31:0] dv, input logic [1:0] er);
    logic ta, tw, tb, bv;
    int n;
    n = 0;
    tb = 1'h0;
    @(posedge aclk);
    aw_a <= a;
    w_d <= dv;
    aw_v <= 1'h1;
    w_v <= 1'h1;
    while (!tb && n < 40) begin
      @(negedge aclk);
      ta = aw_v & aw_rdy;
      tw = w_v & w_rdy;
      tb = b_v & b_r;
      bv = b_v;
      r = b_resp;
      @(posedge aclk);
      if (ta) aw_v <= 1'h0;
      if (tw) w_v <= 1'h0;
      b_r <= bv & !tb; // one stall cycle before taking the answer
      n++;
    end
    chk1(tb, 1'h1);
    chk32({30'h0, r}, {30'h0, er});
  endtask
  task axr(input logic [11:0] a, output logic [31:0] dv, output logic [1:0] rr);
    logic ta, tr, rvs;
    int n;
    n = 0;
    tr = 1'h0;
    @(posedge aclk);
    ar_a <= a;
    ar_v <= 1'h1;
    while (!tr && n < 40) begin
      @(negedge aclk);
      ta = ar_v & ar_rdy;
      tr = r_v & r_r;
      rvs = r_v;
      dv = r_d;
      rr = r_resp;
      @(posedge aclk);
      if (ta) ar_v <= 1'h0;
      r_r <= rvs & !tr;
      n++;
    end
    chk1(tr, 1'h1);
  endtask
  task end_of_test;
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog far beyond the few hundred cycles the run needs
  initial begin
    #(100 * 20000);
    err_total++;
    end_of_test();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    // table rows: program one slot, one host cycle, check, clear by read
    for (int i = 0; i < 11; i++) begin
      axw(rows[i].s ? itm_pkg::ADDR_R5_LO : itm_pkg::ADDR_R4_LO, {24'h0, rows[i].lo},
        itm_pkg::RESP_OKAY);
      axw(rows[i].s ? itm_pkg::ADDR_R5_HI : itm_pkg::ADDR_R4_HI, {24'h0, rows[i].hi},
        itm_pkg::RESP_OKAY);
      i_host.io_cycle(1'h0, rows[i].a);
      @(negedge aclk);
      chk1(irq, |rows[i].st);
      axr(itm_pkg::ADDR_STATUS, d, r);
      chk32(d, {30'h0, rows[i].st});
      @(negedge aclk);
      chk1(irq, 1'h0);
    end
    // both slots on one address hit together; trap word records write and slots
    axw(itm_pkg::ADDR_R4_LO, 32'h30, itm_pkg::RESP_OKAY);
    axw(itm_pkg::ADDR_R4_HI, 32'h12, itm_pkg::RESP_OKAY);
    axw(itm_pkg::ADDR_R5_LO, 32'h30, itm_pkg::RESP_OKAY);
    axw(itm_pkg::ADDR_R5_HI, 32'h12, itm_pkg::RESP_OKAY);
    i_host.io_cycle(1'h1, 16'h1230);
    @(negedge aclk);
    chk1(irq, 1'h1);
    axr(itm_pkg::ADDR_TRAP, d, r);
    chk32(d, 32'h0007_1230);
    axr(itm_pkg::ADDR_STATUS, d, r);
    chk32(d, 32'h3);
    // masked: status still sets, no interrupt
    axw(itm_pkg::ADDR_IRQ_EN, 32'h0, itm_pkg::RESP_OKAY);
    i_host.io_cycle(1'h0, 16'h1230);
    @(negedge aclk);
    chk1(irq, 1'h0);
    axr(itm_pkg::ADDR_STATUS, d, r);
    chk32(d, 32'h3);
    // unmapped place refused both ways
    axr(12'h000, d, r);
    chk32({r, d[29:0]}, {itm_pkg::RESP_SLVERR, 30'h0});
    axw(12'h000, 32'h5, itm_pkg::RESP_SLVERR);
    // a write without byte lane 0 is answered but leaves the high byte alone
    w_s <= 4'h0;
    axw(itm_pkg::ADDR_R4_HI, 32'h55, itm_pkg::RESP_OKAY);
    w_s <= 4'hF;
    axr(itm_pkg::ADDR_R4_HI, d, r);
    chk32(d, 32'h12);
    // pending status and odd enable, then a mid-run reset brings defaults back
    axw(itm_pkg::ADDR_IRQ_EN, 32'h1, itm_pkg::RESP_OKAY);
    i_host.io_cycle(1'h0, 16'h1230);
    aresetn <= 1'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    chk1(irq, 1'h0);
    for (int i = 0; i < 7; i++) begin
      axr(ra[i], d, r);
      chk32(d, rv[i]);
    end
    end_of_test();
  end
endmodule

// ==== tb/itm_host_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// host processor issuing single-cycle i/o cycles
// ****************************************************************
module itm_host_model (
  // clock
  input wire logic aclk,
  // host cycle toward the monitor
  output itm_pkg::itm_io_access_t io_access
);
  initial io_access = '0;

  // one cycle valid; the idle bus shows the inverse so a stale address never looks live
  task automatic io_cycle(input logic wr, input logic [15:0] a);
    @(posedge aclk);
    io_access <= '{1'h1, wr, a};
    @(posedge aclk);
    io_access <= '{1'h0, !wr, ~a};
  endtask
endmodule

// ==== tb/itm_props.sv ====
`timescale 1ns/1ps
// ****************************************************************
// port checker for the io range trap monitor
// ****************************************************************
module itm_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [itm_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // host side
  input wire itm_pkg::itm_io_access_t io_access,
  input wire logic system_management_interrupt
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // bus answers and how long they stand
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid repeated");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == itm_pkg::RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read data not zero");

  // interrupt only from a host cycle, cleared only after a read handshake
  a_irq_cause: assert property ($rose(system_management_interrupt) |->
    $past(io_access.valid)) else $error("interrupt without host cycle");
  a_irq_clear: assert property ($fell(system_management_interrupt) |->
    $past(s_axi_arvalid && s_axi_arready) || $past(s_axi_arvalid && s_axi_arready, 2))
    else $error("interrupt dropped without read");

  // main scenarios seen
  c_irq: cover property ($rose(system_management_interrupt));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == itm_pkg::RESP_SLVERR);
  c_rstall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule

bind itm_top itm_props i_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .io_access(io_access),
  .system_management_interrupt(system_management_interrupt));
